// File: verilog/dacr_pkg.sv
// package: constants and types for the dual converter control block
package dacr_pkg;
  localparam int DACR_WIDTH = 12;
  localparam int DACR_CLK_MHZ = 250;
  // times in nanoseconds as printed
  localparam int DACR_CONV_HS_NS = 3600;
  localparam int DACR_CONV_SLEEP_NS = 6000;
  localparam int DACR_ACQ_NS = 300;
  // cycle counts: least times round up
  localparam int DACR_CONV_HS_CYC = (DACR_CONV_HS_NS * DACR_CLK_MHZ + 999) / 1000;
  localparam int DACR_CONV_SLEEP_CYC = (DACR_CONV_SLEEP_NS * DACR_CLK_MHZ + 999) / 1000;
  localparam int DACR_ACQ_CYC = (DACR_ACQ_NS * DACR_CLK_MHZ + 999) / 1000;
  localparam int DACR_CNT_W = 11;
  localparam logic [DACR_CNT_W-1:0] DACR_CNT_ZERO = 11'h000;
  localparam logic [DACR_CNT_W-1:0] DACR_CNT_ONE = 11'h001;
  localparam logic [DACR_WIDTH-1:0] DACR_RESULT_ZERO = 12'h000;
  typedef enum logic {DACR_HIGH_SAMPLING, DACR_AUTO_SLEEP} dacr_mode_t;
  typedef enum {DACR_TRACK, DACR_CONVERT, DACR_SLEEP} dacr_state_t;
endpackage

// File: verilog/dacr_res_if.sv
// interface: the four conversion results handed from engine to read logic
`timescale 1ns/10ps
`default_nettype none
interface dacr_res_if;
  import dacr_pkg::*;
  logic [DACR_WIDTH-1:0] res_a1;
  logic [DACR_WIDTH-1:0] res_a2;
  logic [DACR_WIDTH-1:0] res_b1;
  logic [DACR_WIDTH-1:0] res_b2;
  logic done;
  modport engine (output res_a1, res_a2, res_b1, res_b2, done);
  modport reader (input res_a1, res_a2, res_b1, res_b2, done);
endinterface
`default_nettype wire

// File: verilog/dacr_sampler.sv
// track/hold and sample capture: latches all four inputs at hold
`timescale 1ns/10ps
`default_nettype none
module dacr_sampler
  import dacr_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  input wire logic hold_strobe,
  input wire logic finish,
  input wire logic [DACR_WIDTH-1:0] in_a1,
  input wire logic [DACR_WIDTH-1:0] in_a2,
  input wire logic [DACR_WIDTH-1:0] in_b1,
  input wire logic [DACR_WIDTH-1:0] in_b2,
  dacr_res_if.engine res
);
  logic [DACR_WIDTH-1:0] held [4];
  logic [DACR_WIDTH-1:0] next_held [4];
  logic [DACR_WIDTH-1:0] result [4];
  logic [DACR_WIDTH-1:0] next_result [4];
  logic [DACR_WIDTH-1:0] src [4];
  logic done;
  logic next_done;

  assign src[0] = in_a1;
  assign src[1] = in_a2;
  assign src[2] = in_b1;
  assign src[3] = in_b2;

  // all four inputs freeze in the same cycle so relative phase is kept
  for (genvar i = 0; i < 4; i++) begin : g_th
    always_comb begin
      next_held[i] = hold_strobe ? src[i] : held[i];
      // results move only at the end, so reads mid-conversion see the last pair
      next_result[i] = finish ? held[i] : result[i];
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        held[i] <= DACR_RESULT_ZERO;
        result[i] <= DACR_RESULT_ZERO;
      end else if (ce) begin
        held[i] <= next_held[i];
        result[i] <= next_result[i];
      end
    end
  end

  always_comb begin
    next_done = done;
    if (hold_strobe) begin
      next_done = 1'b0;
    end else if (finish) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= next_done;
    end
  end

  assign res.res_a1 = result[0];
  assign res.res_a2 = result[1];
  assign res.res_b1 = result[2];
  assign res.res_b2 = result[3];
  assign res.done = done;
endmodule
`default_nettype wire

// File: verilog/dacr_top.sv
// top: conversion timing, busy, sleep and the two-read result port
//
// Contract
// - start falling edge holds both, starts conversion
// - results readable when busy drops
// - first read input one, second input two
// - twelve-bit bus, chip select and read
// - conversion 3.6 us fast, 6 us sleep
// - auto sleep mode sleeps after conversion
// - conversion timing from internal oscillator
// - track resumes at end, acquisition starts
// - acquisition time is 0.3 us
// - busy high from start edge to completion
// - data driven only with select and read low
`timescale 1ns/10ps
`default_nettype none
module dacr_top
  import dacr_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic CONVERSION_START_N,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_N,
  input wire logic PAIR_SELECT,
  input wire logic AUTO_SLEEP_MODE,
  input wire logic [DACR_WIDTH-1:0] PAIR_A_INPUT_ONE,
  input wire logic [DACR_WIDTH-1:0] PAIR_A_INPUT_TWO,
  input wire logic [DACR_WIDTH-1:0] PAIR_B_INPUT_ONE,
  input wire logic [DACR_WIDTH-1:0] PAIR_B_INPUT_TWO,
  output logic BUSY,
  output logic TRACKING,
  output logic ACQUIRED,
  output logic ASLEEP,
  output logic [DACR_WIDTH-1:0] RESULT_BUS_O,
  output logic RESULT_BUS_OE
);
  // pin synchronisers, two stages each
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic start_n_d;
  logic start_n;
  logic cs_n;
  logic rd_n;
  logic psel;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      start_n_d <= 1'b1;
    end else if (CE) begin
      sync1 <= {PAIR_SELECT, READ_N, CHIP_SELECT_N, CONVERSION_START_N};
      sync2 <= sync1;
      start_n_d <= sync2[0];
    end
  end
  assign start_n = sync2[0];
  assign cs_n = sync2[1];
  assign rd_n = sync2[2];
  assign psel = sync2[3];

  logic start_fall;
  assign start_fall = start_n_d & ~start_n;

  // conversion engine, timed by the internal clock only
  dacr_state_t state;
  dacr_state_t next_state;
  dacr_mode_t mode;
  dacr_mode_t next_mode;
  logic [DACR_CNT_W-1:0] cnt;
  logic [DACR_CNT_W-1:0] next_cnt;
  logic [DACR_CNT_W-1:0] acq;
  logic [DACR_CNT_W-1:0] next_acq;
  logic finish;

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cnt = cnt;
    next_acq = (acq != DACR_CNT_ZERO) ? acq - DACR_CNT_ONE : acq;
    finish = 1'b0;
    case (state)
      DACR_TRACK, DACR_SLEEP: begin
        if (start_fall) begin
          next_state = DACR_CONVERT;
          next_mode = AUTO_SLEEP_MODE ? DACR_AUTO_SLEEP : DACR_HIGH_SAMPLING;
          // sleep mode includes wake-up, hence the longer time
          next_cnt = AUTO_SLEEP_MODE ? DACR_CNT_W'(DACR_CONV_SLEEP_CYC - 1)
                                     : DACR_CNT_W'(DACR_CONV_HS_CYC - 1);
        end
      end
      DACR_CONVERT: begin
        if (cnt == DACR_CNT_ZERO) begin
          finish = 1'b1;
          next_acq = DACR_CNT_W'(DACR_ACQ_CYC);
          next_state = (mode == DACR_AUTO_SLEEP) ? DACR_SLEEP : DACR_TRACK;
        end else begin
          next_cnt = cnt - DACR_CNT_ONE;
        end
      end
      default: next_state = DACR_TRACK;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state <= DACR_TRACK;
      mode <= DACR_HIGH_SAMPLING;
      cnt <= DACR_CNT_ZERO;
      acq <= DACR_CNT_ZERO;
    end else if (CE) begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      acq <= next_acq;
    end
  end

  dacr_res_if res ();

  dacr_sampler u_sampler (
    .clk(MCLK),
    .ce(CE),
    .nrst(NRST),
    .hold_strobe(start_fall && (state != DACR_CONVERT)),
    .finish(finish),
    .in_a1(PAIR_A_INPUT_ONE),
    .in_a2(PAIR_A_INPUT_TWO),
    .in_b1(PAIR_B_INPUT_ONE),
    .in_b2(PAIR_B_INPUT_TWO),
    .res(res.engine)
  );

  // read side: a read ends on the rising edge of the combined strobe
  logic rd_act;
  logic rd_act_d;
  logic second;
  logic next_second;
  logic [DACR_WIDTH-1:0] next_bus;
  logic next_oe;
  logic next_busy;

  assign rd_act = ~cs_n & ~rd_n;

  always_comb begin
    next_second = second;
    if (start_fall && state != DACR_CONVERT) begin
      next_second = 1'b0;
    end else if (rd_act_d && !rd_act) begin
      next_second = ~second;
    end
    case ({psel, second})
      2'b00: next_bus = res.res_a1;
      2'b01: next_bus = res.res_a2;
      2'b10: next_bus = res.res_b1;
      default: next_bus = res.res_b2;
    endcase
    next_oe = rd_act;
    next_busy = (next_state == DACR_CONVERT);
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      rd_act_d <= 1'b0;
      second <= 1'b0;
      RESULT_BUS_O <= DACR_RESULT_ZERO;
      RESULT_BUS_OE <= 1'b0;
      BUSY <= 1'b0;
      TRACKING <= 1'b1;
      ACQUIRED <= 1'b1;
      ASLEEP <= 1'b0;
    end else if (CE) begin
      rd_act_d <= rd_act;
      second <= next_second;
      // reads during conversion return the previous pair, not garbage
      RESULT_BUS_O <= next_bus;
      RESULT_BUS_OE <= next_oe;
      BUSY <= next_busy;
      TRACKING <= (next_state != DACR_CONVERT);
      ACQUIRED <= (next_state != DACR_CONVERT) && (next_acq == DACR_CNT_ZERO);
      ASLEEP <= (next_state == DACR_SLEEP);
    end
  end
endmodule
`default_nettype wire

// File: test/dacr_props.sv
// checker: conversion, acquisition and read-strobe timing at the top ports
`timescale 1ns/10ps
`default_nettype none
module dacr_props
  import dacr_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic CONVERSION_START_N,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_N,
  input wire logic AUTO_SLEEP_MODE,
  input wire logic BUSY,
  input wire logic TRACKING,
  input wire logic ACQUIRED,
  input wire logic ASLEEP,
  input wire logic RESULT_BUS_OE
);
  logic [11:0] busy_cnt, next_busy_cnt, trk_cnt, next_trk_cnt;
  logic mode_lat, next_mode_lat;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST || !CE);
  always_comb begin
    next_busy_cnt = BUSY ? busy_cnt + 12'h001 : 12'h000;
    // saturates so a long idle spell cannot wrap into a false match
    next_trk_cnt = TRACKING ? trk_cnt + {11'h000, trk_cnt != 12'hfff} : 12'h000;
    next_mode_lat = BUSY ? mode_lat : AUTO_SLEEP_MODE;
  end
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      busy_cnt <= 12'h000;
      trk_cnt <= 12'h000;
      mode_lat <= 1'b0;
    end else if (CE) begin
      // counts follow enabled cycles only, as the block itself does
      busy_cnt <= next_busy_cnt;
      trk_cnt <= next_trk_cnt;
      mode_lat <= next_mode_lat;
    end
  end
  AST_BUSY_START: assert property ($fell(CONVERSION_START_N) && ACQUIRED |-> ##[2:5] $rose(BUSY))
    else $error("busy did not follow start");
  AST_BUSY_CAUSE: assert property ($rose(BUSY) |-> !$past(CONVERSION_START_N, 2))
    else $error("busy rose without start");
  AST_CONV_LEN: assert property ($fell(BUSY) |-> busy_cnt == (mode_lat ? DACR_CONV_SLEEP_CYC : DACR_CONV_HS_CYC))
    else $error("conversion length wrong");
  AST_TRACK: assert property (TRACKING != BUSY)
    else $error("tracking not opposite of busy");
  AST_ACQ_TIME: assert property ($rose(ACQUIRED) |-> trk_cnt == DACR_ACQ_CYC)
    else $error("acquisition time wrong");
  AST_ACQ_TRACK: assert property (ACQUIRED |-> TRACKING)
    else $error("acquired while holding");
  AST_SLEEP: assert property ($fell(BUSY) |-> ASLEEP == mode_lat)
    else $error("sleep state wrong after conversion");
  AST_OE_CAUSE: assert property (RESULT_BUS_OE |-> !$past(CHIP_SELECT_N, 3) && !$past(READ_N, 3))
    else $error("bus driven without select and read");
  cover property ($fell(BUSY) && ASLEEP);
  cover property ($fell(BUSY) && !ASLEEP);
  cover property ($rose(RESULT_BUS_OE));
endmodule
bind dacr_top dacr_props u_props (.MCLK(MCLK), .NRST(NRST), .CE(CE),
  .CONVERSION_START_N(CONVERSION_START_N), .CHIP_SELECT_N(CHIP_SELECT_N), .READ_N(READ_N),
  .AUTO_SLEEP_MODE(AUTO_SLEEP_MODE), .BUSY(BUSY), .TRACKING(TRACKING), .ACQUIRED(ACQUIRED),
  .ASLEEP(ASLEEP), .RESULT_BUS_OE(RESULT_BUS_OE));
`default_nettype wire

// File: test/dacr_host.sv
// partner: host that starts conversions and reads results
`timescale 1ns/10ps
`default_nettype none
module dacr_host
  import dacr_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  input wire logic acq,
  input wire logic oe,
  input wire logic [DACR_WIDTH-1:0] bus,
  output logic start_n,
  output logic cs_n,
  output logic rd_n,
  output logic sel
);
  initial begin
    start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    sel = 1'b0;
  end
  task automatic start(output bit ok);
    int n;
    n = 0;
    repeat (DACR_ACQ_CYC) @(posedge clk);
    while (!acq && n < 2000) begin
      @(posedge clk);
      n++;
    end
    ok = acq;
    start_n <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!busy && n < 8);
    start_n <= 1'b1;
    ok = ok && busy;
  endtask
  task automatic finish(output int cyc);
    cyc = 1;
    while (cyc < 2000) begin
      @(posedge clk);
      if (!busy) break;
      cyc++;
    end
  endtask
  task automatic rd(input logic s, output logic [DACR_WIDTH-1:0] d, output bit ok);
    int n;
    sel <= s;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!oe && n < 8);
    ok = oe;
    d = bus;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (oe && n < 8);
    ok = ok && !oe;
  endtask
endmodule
`default_nettype wire

// File: test/dacr_top_bench.sv
// bench: random conversions and read sequences through the host model
`timescale 1ns/10ps
`default_nettype none
module dacr_top_bench
  import dacr_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b0;
  logic ce = 1'b1;
  logic [DACR_WIDTH-1:0] in_v [4] = '{default: 12'h000};
  logic [DACR_WIDTH-1:0] held [4];
  logic [DACR_WIDTH-1:0] bus;
  logic start_n, cs_n, rd_n, sel, busy, trk, acq, slp, oe;
  int error_cnt = 0;
  int n_checks = 0;
  initial forever #2 mclk = ~mclk;
  dacr_top dut (.MCLK(mclk), .NRST(nrst), .CE(ce), .CONVERSION_START_N(start_n),
    .CHIP_SELECT_N(cs_n), .READ_N(rd_n), .PAIR_SELECT(sel), .AUTO_SLEEP_MODE(mode),
    .PAIR_A_INPUT_ONE(in_v[0]), .PAIR_A_INPUT_TWO(in_v[1]), .PAIR_B_INPUT_ONE(in_v[2]),
    .PAIR_B_INPUT_TWO(in_v[3]), .BUSY(busy), .TRACKING(trk), .ACQUIRED(acq), .ASLEEP(slp),
    .RESULT_BUS_O(bus), .RESULT_BUS_OE(oe));
  dacr_host host (.clk(mclk), .busy(busy), .acq(acq), .oe(oe), .bus(bus), .start_n(start_n),
    .cs_n(cs_n), .rd_n(rd_n), .sel(sel));
  // index is {pair, second read}
  function automatic logic [DACR_WIDTH-1:0] exp_res(logic s, logic second);
    return held[{s, second}];
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wd(bit ok);
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH handshake exp 1 got 0");
      stop_test();
    end
  endtask
  initial begin
    int cyc, nr;
    bit ok;
    logic s;
    logic [DACR_WIDTH-1:0] d;
    logic [16:0] snap;
    void'($urandom(32'h7312));
    repeat (16) @(posedge mclk);
    chk("reset", 32'h6, {busy, trk, acq, oe});
    nrst <= 1'b1;
    for (int t = 0; t < 12; t++) begin
      mode <= (t < 2) ? 1'(t) : 1'($urandom);
      foreach (in_v[i]) in_v[i] <= (t == 2) ? 12'hfff : 12'($urandom);
      host.start(ok);
      wd(ok);
      held = in_v;
      // inputs move after hold; results must not follow them
      foreach (in_v[i]) in_v[i] <= ~held[i];
      host.finish(cyc);
      chk("conv cycles", mode ? DACR_CONV_SLEEP_CYC : DACR_CONV_HS_CYC, cyc);
      chk("asleep", {31'h0, mode}, {31'h0, slp});
      // odd counts leave the order mid-pair for the next start
      nr = (t == 3) ? 1 : 1 + $urandom_range(2);
      for (int r = 0; r < nr; r++) begin
        s = 1'($urandom);
        host.rd(s, d, ok);
        wd(ok);
        chk("result", exp_res(s, r[0]), d);
      end
      // enable low mid acquisition: nothing may move, acquisition must not advance
      ce <= 1'b0;
      @(posedge mclk);
      snap = {busy, trk, acq, slp, oe, bus};
      repeat (1 + $urandom_range(7)) @(posedge mclk);
      chk("freeze", {15'h0, snap}, {15'h0, busy, trk, acq, slp, oe, bus});
      ce <= 1'b1;
      $display("test %0d done", t);
    end
    stop_test();
  end
endmodule
`default_nettype wire
